// *** src/srsf_top.sv ***
// Status-flag logic of a serial port: transmit-empty, receive-full and
// overrun flags with their read-then-write-zero clear, behind Wishbone.
// Assumes the shift engines run on i_clk and give one-cycle event pulses;
// the standby request is an asynchronous pin.
//
// Overview of operation
// - Transmit-empty flag goes to one at reset and in standby.
// - Transmit-empty flag is one whenever transmit enable is cleared.
// - Transfer from holding to shift register sets transmit-empty.
// - Software clears transmit-empty by reading one, then writing zero.
// - Receive-full, bit 6, resets zero; standby or read-then-zero clears it.
// - Error-free character moved into receive holding sets receive-full.
// - Receive errors and clearing receive enable leave data and flag alone.
// - Character completing while receive-full is set causes overrun, is lost.
// - Overrun, bit 5, resets zero; standby or read-then-zero clears it.
// - Overrun sets when next character ends with receive-full set.
// - Clearing receive enable keeps the overrun flag as it was.
// - On overrun the receive holding register keeps the earlier character.
// - No reception continues while the overrun flag is set.
// - In synchronous mode transmission also stops while overrun is set.
`timescale 1ns/1ps
`default_nettype none

module srsf_top
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_cyc,
    input wire logic i_stb,
    input wire logic i_we,
    input wire logic [srsf_pkg::ADR_W-1:0] i_adr,
    input wire logic [3:0] i_sel,
    input wire logic [srsf_pkg::DAT_W-1:0] i_dat,
    output logic o_ack,
    output logic [srsf_pkg::DAT_W-1:0] o_dat,
    output logic o_irq,
    input wire logic i_standby,
    input wire logic i_tx_load,
    output logic [srsf_pkg::CHAR_W-1:0] o_tx_data,
    output logic o_tx_ready,
    input wire logic i_rx_done,
    input wire logic i_rx_err,
    input wire logic [srsf_pkg::CHAR_W-1:0] i_rx_data,
    output logic o_rx_allow
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Address match used by every read and write decode below.
    function automatic logic hit(input logic [srsf_pkg::ADR_W-1:0] adr,
                                 input logic [srsf_pkg::ADR_W-1:0] off);
        hit = (adr == off);
    endfunction : hit

    srsf_pkg::srsf_state_s q;
    srsf_pkg::srsf_state_s next_q;
    logic standby;
    logic acc;
    logic rd;
    logic wr;
    logic tx_take;
    logic rx_ok;
    logic [srsf_pkg::IRQ_N-1:0] ev;

    // Standby arrives from outside the clock domain.
    srsf_sync u_standby_sync
    (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async(i_standby),
        .o_level(standby)
    );

    // ------------------------------------------------------------------
    // Bus qualification
    // ------------------------------------------------------------------

    // A request is answered one cycle after it appears; a write commits
    // at the acknowledge edge, when the master also sees ack.
    assign acc = i_cyc & i_stb & ~q.ack;
    assign rd = acc & ~i_we;
    assign wr = i_cyc & i_stb & i_we & q.ack & i_sel[0];
    assign tx_take = i_tx_load & q.tx_ready;
    // An event from the receiver counts only while reception is allowed.
    assign rx_ok = i_rx_done & q.rx_allow;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------

    // Register-write clears come before the sets, so a set in the same cycle
    // as such a clear wins; standby comes after both and overrides any set.
    always_comb
    begin
        next_q = q;
        ev = '0;
        next_q.ack = acc;
        next_q.dat = '0;

        // Read data and read-side arming of the flag clears.
        if (rd)
        begin
            if (hit(i_adr, srsf_pkg::OFF_STATUS))
            begin
                next_q.dat[srsf_pkg::BIT_TX_EMPTY] = q.tx_holding_empty;
                next_q.dat[srsf_pkg::BIT_RX_FULL] = q.rx_holding_full;
                next_q.dat[srsf_pkg::BIT_OVERRUN] = q.rx_overrun_flag;
                next_q.arm_empty = q.arm_empty | q.tx_holding_empty;
                next_q.arm_full = q.arm_full | q.rx_holding_full;
                next_q.arm_overrun = q.arm_overrun | q.rx_overrun_flag;
            end
            else if (hit(i_adr, srsf_pkg::OFF_CONTROL))
            begin
                next_q.dat[srsf_pkg::BIT_TX_ENABLE] = q.tx_enable_bit;
                next_q.dat[srsf_pkg::BIT_RX_ENABLE] = q.rx_enable_bit;
                next_q.dat[srsf_pkg::BIT_SYNC_MODE] = q.sync_mode;
            end
            else if (hit(i_adr, srsf_pkg::OFF_TX_DATA))
            begin
                next_q.dat[srsf_pkg::CHAR_W-1:0] = q.tx_holding_reg;
            end
            else if (hit(i_adr, srsf_pkg::OFF_RX_DATA))
            begin
                next_q.dat[srsf_pkg::CHAR_W-1:0] = q.rx_holding_reg;
            end
            else if (hit(i_adr, srsf_pkg::OFF_IRQ_STATUS))
            begin
                next_q.dat[srsf_pkg::IRQ_N-1:0] = q.irq_sts;
            end
            else if (hit(i_adr, srsf_pkg::OFF_IRQ_ENABLE))
            begin
                next_q.dat[srsf_pkg::IRQ_N-1:0] = q.irq_en;
            end
        end

        // Register writes; unmapped offsets are acknowledged and dropped.
        if (wr)
        begin
            if (hit(i_adr, srsf_pkg::OFF_STATUS))
            begin
                if (!i_dat[srsf_pkg::BIT_TX_EMPTY] && q.arm_empty)
                begin
                    next_q.tx_holding_empty = 1'b0;
                end
                if (!i_dat[srsf_pkg::BIT_RX_FULL] && q.arm_full)
                begin
                    next_q.rx_holding_full = 1'b0;
                end
                if (!i_dat[srsf_pkg::BIT_OVERRUN] && q.arm_overrun)
                begin
                    next_q.rx_overrun_flag = 1'b0;
                end
                next_q.arm_empty = 1'b0;
                next_q.arm_full = 1'b0;
                next_q.arm_overrun = 1'b0;
            end
            else if (hit(i_adr, srsf_pkg::OFF_CONTROL))
            begin
                next_q.tx_enable_bit = i_dat[srsf_pkg::BIT_TX_ENABLE];
                next_q.rx_enable_bit = i_dat[srsf_pkg::BIT_RX_ENABLE];
                next_q.sync_mode = i_dat[srsf_pkg::BIT_SYNC_MODE];
            end
            else if (hit(i_adr, srsf_pkg::OFF_TX_DATA))
            begin
                next_q.tx_holding_reg = i_dat[srsf_pkg::CHAR_W-1:0];
            end
            else if (hit(i_adr, srsf_pkg::OFF_IRQ_ENABLE))
            begin
                next_q.irq_en = i_dat[srsf_pkg::IRQ_N-1:0];
            end
        end

        if (tx_take)
        begin
            next_q.tx_holding_empty = 1'b1;
            ev[srsf_pkg::IRQ_TX_EMPTY] = 1'b1;
        end

        // Reception; errored characters change nothing at all.
        // errors leave state
        if (rx_ok && !i_rx_err)
        begin
            if (q.rx_holding_full)
            begin
                next_q.rx_overrun_flag = 1'b1;
                ev[srsf_pkg::IRQ_OVERRUN] = 1'b1;
            end
            else
            begin
                next_q.rx_holding_reg = i_rx_data;
                next_q.rx_holding_full = 1'b1;
                ev[srsf_pkg::IRQ_RX_FULL] = 1'b1;
            end
        end

        if (!next_q.tx_enable_bit)
        begin
            next_q.tx_holding_empty = 1'b1;
        end

        // Standby forces the flags back to their reset values.
        // standby sets empty
        if (standby)
        begin
            next_q.tx_holding_empty = srsf_pkg::RST_TX_EMPTY;
            next_q.rx_holding_full = srsf_pkg::RST_RX_FULL;
            next_q.rx_overrun_flag = srsf_pkg::RST_OVERRUN;
            next_q.arm_empty = 1'b0;
            next_q.arm_full = 1'b0;
            next_q.arm_overrun = 1'b0;
        end

        // Sticky interrupt status; an event beats a clear in one cycle.
        if (wr && hit(i_adr, srsf_pkg::OFF_IRQ_CLEAR))
        begin
            next_q.irq_sts = q.irq_sts & ~i_dat[srsf_pkg::IRQ_N-1:0];
        end
        next_q.irq_sts = next_q.irq_sts | ev;
        next_q.irq = |(next_q.irq_sts & next_q.irq_en);

        // Outputs are taken from the next state so they match the flags.
        // overrun stops reception
        next_q.rx_allow = next_q.rx_enable_bit & ~next_q.rx_overrun_flag;
        next_q.tx_ready = next_q.tx_enable_bit & ~next_q.tx_holding_empty
                          & ~(next_q.sync_mode & next_q.rx_overrun_flag);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            q <= '0;
            q.tx_holding_empty <= srsf_pkg::RST_TX_EMPTY;
            q.rx_holding_full <= srsf_pkg::RST_RX_FULL;
            q.rx_overrun_flag <= srsf_pkg::RST_OVERRUN;
            q.tx_holding_reg <= srsf_pkg::RST_CHAR;
            q.rx_holding_reg <= srsf_pkg::RST_CHAR;
            q.irq_sts <= srsf_pkg::RST_IRQ;
            q.irq_en <= srsf_pkg::RST_IRQ;
        end
        else
        begin
            q <= next_q;
        end
    end

    // Every output is a field of the registered state.
    assign o_ack = q.ack;
    assign o_dat = q.dat;
    assign o_irq = q.irq;
    assign o_tx_data = q.tx_holding_reg;
    assign o_tx_ready = q.tx_ready;
    assign o_rx_allow = q.rx_allow;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // Transmit enable off always shows an empty holding register.
    // empty while disabled
    a_tx_off_empty: assert property (!q.tx_enable_bit |-> q.tx_holding_empty)
        else $error("transmit-empty low while transmit disabled");

    // A taken transfer leaves the holding register empty next cycle.
    // load sets empty
    a_tx_load_empty: assert property (tx_take |=> q.tx_holding_empty)
        else $error("transmit-empty not set after shift load");

    // One cycle of standby leaves all three flags at reset values.
    // standby flag values
    a_standby_flags: assert property (standby |=> (q.tx_holding_empty
        && !q.rx_holding_full && !q.rx_overrun_flag))
        else $error("flags not reset by standby");

    // A clean character into an empty holding register is stored.
    // load character
    a_rx_load_data: assert property ((rx_ok && !i_rx_err
        && !q.rx_holding_full && !standby) |=> (q.rx_holding_full
        && q.rx_holding_reg == $past(i_rx_data)))
        else $error("received character not loaded");

    // An overrun keeps the old character and raises the flag.
    // overrun keeps data
    a_overrun_keep: assert property ((rx_ok && !i_rx_err
        && q.rx_holding_full && !standby) |=> (q.rx_overrun_flag
        && $stable(q.rx_holding_reg)))
        else $error("overrun lost old data or flag not set");

    // An errored character changes neither data nor flag.
    // errors change nothing
    a_rx_err_still: assert property ((i_rx_done && i_rx_err && !wr
        && !standby) |=> ($stable(q.rx_holding_reg)
        && $stable(q.rx_holding_full)))
        else $error("receive error changed holding state");

    // Reception is refused for as long as an overrun is pending.
    // no reception
    a_ovr_blocks_rx: assert property (q.rx_overrun_flag |-> !o_rx_allow)
        else $error("reception allowed during overrun");

    // In synchronous mode an overrun also holds the transmitter.
    // sync blocks transmit
    a_ovr_blocks_tx: assert property ((q.rx_overrun_flag && q.sync_mode)
        |-> !o_tx_ready)
        else $error("transmit allowed during synchronous overrun");

    // Writing zero without a prior read leaves a set flag standing.
    // unarmed write ignored
    a_clear_unarmed: assert property ((wr && hit(i_adr,
        srsf_pkg::OFF_STATUS) && !q.arm_full && q.rx_holding_full
        && !standby) |=> q.rx_holding_full)
        else $error("receive-full cleared without prior read");

    // Read-then-zero clears the overrun flag on the acknowledge edge.
    // armed clear works
    a_ovr_clear: assert property ((wr && hit(i_adr, srsf_pkg::OFF_STATUS)
        && q.arm_overrun && !i_dat[srsf_pkg::BIT_OVERRUN]
        && !(rx_ok && !i_rx_err && q.rx_holding_full))
        |=> !q.rx_overrun_flag)
        else $error("armed overrun clear did not take");

    // Each acknowledge lasts exactly one cycle.
    a_ack_single: assert property (o_ack |=> !o_ack)
        else $error("ack held longer than one cycle");

endmodule : srsf_top

`default_nettype wire

// *** inc/srsf_pkg.sv ***
// Shared constants and the state layout of the serial status-flag block.
// Assumes a 32-bit classic Wishbone slave port and a byte-wide data path.
package srsf_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int CHAR_W = 8;
    localparam int IRQ_N = 3;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADR_W-1:0] OFF_STATUS = 8'h00;
    localparam logic [ADR_W-1:0] OFF_CONTROL = 8'h04;
    localparam logic [ADR_W-1:0] OFF_TX_DATA = 8'h08;
    localparam logic [ADR_W-1:0] OFF_RX_DATA = 8'h0c;
    localparam logic [ADR_W-1:0] OFF_IRQ_STATUS = 8'h10;
    localparam logic [ADR_W-1:0] OFF_IRQ_CLEAR = 8'h14;
    localparam logic [ADR_W-1:0] OFF_IRQ_ENABLE = 8'h18;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_TX_EMPTY = 7;
    localparam int BIT_RX_FULL = 6;
    localparam int BIT_OVERRUN = 5;
    localparam int BIT_TX_ENABLE = 5;
    localparam int BIT_RX_ENABLE = 4;
    localparam int BIT_SYNC_MODE = 0;
    localparam int IRQ_TX_EMPTY = 0;
    localparam int IRQ_RX_FULL = 1;
    localparam int IRQ_OVERRUN = 2;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic RST_TX_EMPTY = 1'b1;
    localparam logic RST_RX_FULL = 1'b0;
    localparam logic RST_OVERRUN = 1'b0;
    localparam logic [CHAR_W-1:0] RST_CHAR = 8'h00;
    localparam logic [IRQ_N-1:0] RST_IRQ = 3'h0;
    localparam int SYNC_STAGES = 2;

    // ------------------------------------------------------------------
    // Whole state of the flag block, registered as one word
    // ------------------------------------------------------------------
    typedef struct packed {
        logic ack;
        logic [DAT_W-1:0] dat;
        logic tx_enable_bit;
        logic rx_enable_bit;
        logic sync_mode;
        logic tx_holding_empty;
        logic rx_holding_full;
        logic rx_overrun_flag;
        logic arm_empty;
        logic arm_full;
        logic arm_overrun;
        logic [CHAR_W-1:0] tx_holding_reg;
        logic [CHAR_W-1:0] rx_holding_reg;
        logic [IRQ_N-1:0] irq_sts;
        logic [IRQ_N-1:0] irq_en;
        logic irq;
        logic tx_ready;
        logic rx_allow;
    } srsf_state_s;

endpackage : srsf_pkg

// *** src/srsf_sync.sv ***
// Two-stage level synchroniser for a pin that arrives from outside the clock.
// Assumes the level is slow compared to the clock; pulses may be missed.
`timescale 1ns/1ps
`default_nettype none

module srsf_sync
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_async,
    output logic o_level
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic first;
        logic second;
    } srsf_sync_s;

    srsf_sync_s q;
    srsf_sync_s next_q;

    // The first stage is only ever read by the second stage.
    always_comb
    begin
        next_q.first = i_async;
        next_q.second = q.first;
    end

    // Reset loads constants only; the pin is caught after release.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign o_level = q.second;

endmodule : srsf_sync

`default_nettype wire

// *** tb/srsf_top_tb.sv ***
// Self-checking bench for the serial status-flag block.
// Assumes the package srsf_pkg is compiled first; drives all ports itself.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end

module srsf_top_tb;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_cyc = 1'b0;
    logic i_stb = 1'b0;
    logic i_we = 1'b0;
    logic [7:0] i_adr = 8'h00;
    logic [3:0] i_sel = 4'hf;
    logic [31:0] i_dat = 32'h0;
    logic o_ack;
    logic [31:0] o_dat;
    logic o_irq;
    logic i_standby = 1'b0;
    logic i_tx_load = 1'b0;
    logic [7:0] o_tx_data;
    logic o_tx_ready;
    logic i_rx_done = 1'b0;
    logic i_rx_err = 1'b0;
    logic [7:0] i_rx_data = 8'h00;
    logic o_rx_allow;
    int fails = 0;
    int cmp_count = 0;
    logic [31:0] rd;

    srsf_top srsf_top_i (.i_clk(i_clk), .i_rst(i_rst), .i_cyc(i_cyc),
        .i_stb(i_stb), .i_we(i_we), .i_adr(i_adr), .i_sel(i_sel),
        .i_dat(i_dat), .o_ack(o_ack), .o_dat(o_dat), .o_irq(o_irq),
        .i_standby(i_standby), .i_tx_load(i_tx_load), .o_tx_data(o_tx_data),
        .o_tx_ready(o_tx_ready), .i_rx_done(i_rx_done), .i_rx_err(i_rx_err),
        .i_rx_data(i_rx_data), .o_rx_allow(o_rx_allow));

    // Free-running 10 MHz clock.
    always #50 i_clk = ~i_clk;

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    // Prints the counts and the verdict, then ends the run.
    task stop_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test

    // One classic Wishbone cycle; waits for ack under a bounded count.
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        i_cyc <= 1'b1;
        i_stb <= 1'b1;
        i_we <= we;
        i_adr <= a;
        i_dat <= d;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (o_ack !== 1'b1 && n < 20);
        rd = o_dat;
        i_cyc <= 1'b0;
        i_stb <= 1'b0;
        if (n >= 20)
        begin
            fails++;
            stop_test();
        end
    endtask : wb

    // Reads a register and compares it with the expected word.
    task rchk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        `CHK(rd, exp)
    endtask : rchk

    // Status word from the three flag values.
    function automatic logic [31:0] st(input logic e, input logic f,
                                       input logic o);
        st = 32'h0;
        st[srsf_pkg::BIT_TX_EMPTY] = e;
        st[srsf_pkg::BIT_RX_FULL] = f;
        st[srsf_pkg::BIT_OVERRUN] = o;
    endfunction : st

    // Read-then-write clear of the status flags; d keeps bits written 1.
    task sclr(input logic [31:0] d);
        wb(1'b0, srsf_pkg::OFF_STATUS, 32'h0);
        wb(1'b1, srsf_pkg::OFF_STATUS, d);
    endtask : sclr

    // One-cycle receive completion pulse, then let the flags land.
    task rx(input logic err, input logic [7:0] d);
        @(posedge i_clk);
        i_rx_done <= 1'b1;
        i_rx_err <= err;
        i_rx_data <= d;
        @(posedge i_clk);
        i_rx_done <= 1'b0;
        i_rx_err <= 1'b0;
        @(posedge i_clk);
    endtask : rx

    // One-cycle transfer pulse from the transmit shifter.
    task txl;
        @(posedge i_clk);
        i_tx_load <= 1'b1;
        @(posedge i_clk);
        i_tx_load <= 1'b0;
        @(posedge i_clk);
    endtask : txl

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_reset;
        rchk(srsf_pkg::OFF_STATUS, st(1'b1, 1'b0, 1'b0));
        rchk(srsf_pkg::OFF_CONTROL, 32'h0);
        rchk(8'h40, 32'h0);
        @(negedge i_clk);
        `CHK({o_tx_ready, o_rx_allow}, 2'b00)
    endtask : t_reset

    task t_tx;
        wb(1'b1, srsf_pkg::OFF_CONTROL, 32'h20);
        // The status read in the reset scenario armed the empty flag, and
        // any status write disarms, so write all ones first.
        wb(1'b1, srsf_pkg::OFF_STATUS, 32'he0);
        // A zero without a prior read, and a one after a read, do nothing.
        wb(1'b1, srsf_pkg::OFF_STATUS, 32'h0);
        rchk(srsf_pkg::OFF_STATUS, st(1'b1, 1'b0, 1'b0));
        wb(1'b1, srsf_pkg::OFF_STATUS, 32'h80);
        rchk(srsf_pkg::OFF_STATUS, st(1'b1, 1'b0, 1'b0));
        sclr(32'h0);
        rchk(srsf_pkg::OFF_STATUS, st(1'b0, 1'b0, 1'b0));
        wb(1'b1, srsf_pkg::OFF_TX_DATA, 32'ha5);
        @(negedge i_clk);
        `CHK({o_tx_ready, o_tx_data}, 9'h1a5)
        txl();
        rchk(srsf_pkg::OFF_STATUS, st(1'b1, 1'b0, 1'b0));
        `CHK(o_tx_ready, 1'b0)
        sclr(32'h0);
        wb(1'b1, srsf_pkg::OFF_CONTROL, 32'h0);
        rchk(srsf_pkg::OFF_STATUS, st(1'b1, 1'b0, 1'b0));
    endtask : t_tx

    task t_rx;
        wb(1'b1, srsf_pkg::OFF_CONTROL, 32'h10);
        rx(1'b1, 8'h11);
        rchk(srsf_pkg::OFF_STATUS, st(1'b1, 1'b0, 1'b0));
        rchk(srsf_pkg::OFF_RX_DATA, 32'h0);
        rx(1'b0, 8'h3c);
        // An unarmed zero write must leave the new full flag standing.
        wb(1'b1, srsf_pkg::OFF_STATUS, 32'h0);
        rchk(srsf_pkg::OFF_STATUS, st(1'b1, 1'b1, 1'b0));
        rchk(srsf_pkg::OFF_RX_DATA, 32'h3c);
        rx(1'b0, 8'h99);
        rchk(srsf_pkg::OFF_STATUS, st(1'b1, 1'b1, 1'b1));
        rchk(srsf_pkg::OFF_RX_DATA, 32'h3c);
        `CHK(o_rx_allow, 1'b0)
        // Full is cleared but overrun kept, so a character that got through
        // would load; reception must stay blocked while overrun stands.
        sclr(32'h20);
        rx(1'b0, 8'h77);
        rchk(srsf_pkg::OFF_STATUS, st(1'b1, 1'b0, 1'b1));
        rchk(srsf_pkg::OFF_RX_DATA, 32'h3c);
        wb(1'b1, srsf_pkg::OFF_CONTROL, 32'h0);
        rchk(srsf_pkg::OFF_STATUS, st(1'b1, 1'b0, 1'b1));
        sclr(32'h0);
        rchk(srsf_pkg::OFF_STATUS, st(1'b1, 1'b0, 1'b0));
    endtask : t_rx

    task t_sync;
        wb(1'b1, srsf_pkg::OFF_CONTROL, 32'h31);
        sclr(32'h0);
        @(negedge i_clk);
        `CHK(o_tx_ready, 1'b1)
        rx(1'b0, 8'h01);
        rx(1'b0, 8'h02);
        @(negedge i_clk);
        `CHK(o_tx_ready, 1'b0)
        txl();
        rchk(srsf_pkg::OFF_STATUS, st(1'b0, 1'b1, 1'b1));
        sclr(32'h0);
        @(negedge i_clk);
        `CHK({o_tx_ready, o_rx_allow}, 2'b11)
    endtask : t_sync

    task t_irq;
        wb(1'b1, srsf_pkg::OFF_IRQ_CLEAR, 32'h7);
        rchk(srsf_pkg::OFF_IRQ_STATUS, 32'h0);
        wb(1'b1, srsf_pkg::OFF_IRQ_ENABLE, 32'h2);
        @(negedge i_clk);
        `CHK(o_irq, 1'b0)
        rx(1'b0, 8'h5a);
        rchk(srsf_pkg::OFF_IRQ_STATUS, 32'h2);
        `CHK(o_irq, 1'b1)
        wb(1'b1, srsf_pkg::OFF_IRQ_ENABLE, 32'h0);
        @(negedge i_clk);
        `CHK(o_irq, 1'b0)
        wb(1'b1, srsf_pkg::OFF_IRQ_ENABLE, 32'h2);
        wb(1'b1, srsf_pkg::OFF_IRQ_CLEAR, 32'h2);
        @(negedge i_clk);
        `CHK(o_irq, 1'b0)
        rchk(srsf_pkg::OFF_IRQ_CLEAR, 32'h0);
    endtask : t_irq

    task t_standby;
        // Receive enable goes off while the full flag and its data stand.
        wb(1'b1, srsf_pkg::OFF_CONTROL, 32'h01);
        rchk(srsf_pkg::OFF_STATUS, st(1'b1, 1'b1, 1'b0));
        rchk(srsf_pkg::OFF_RX_DATA, 32'h5a);
        // A write without byte lane zero selected is dropped.
        i_sel <= 4'he;
        wb(1'b1, srsf_pkg::OFF_CONTROL, 32'h30);
        i_sel <= 4'hf;
        rchk(srsf_pkg::OFF_CONTROL, 32'h01);
        @(posedge i_clk);
        i_standby <= 1'b1;
        repeat (5) @(posedge i_clk);
        rchk(srsf_pkg::OFF_STATUS, st(1'b1, 1'b0, 1'b0));
        i_standby <= 1'b0;
        repeat (5) @(posedge i_clk);
        rchk(srsf_pkg::OFF_STATUS, st(1'b1, 1'b0, 1'b0));
        rchk(srsf_pkg::OFF_CONTROL, 32'h01);
    endtask : t_standby

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        t_reset();
        t_tx();
        t_rx();
        t_sync();
        t_irq();
        t_standby();
        stop_test();
    end
endmodule : srsf_top_tb

`default_nettype wire
